// File: verilog/lsmx_regs.vh
// Constants shared by the block-transfer and exclusive-access execution unit.
`ifndef LSMX_REGS_VH
`define LSMX_REGS_VH
// Operation codes on the command port.
`define LSMX_OP_LOAD_MULTIPLE 3'h0
`define LSMX_OP_STORE_MULTIPLE 3'h1
`define LSMX_OP_PUSH 3'h2
`define LSMX_OP_POP 3'h3
`define LSMX_OP_LOAD_EXCLUSIVE 3'h4
`define LSMX_OP_STORE_EXCLUSIVE 3'h5
`define LSMX_OP_CLEAR_EXCLUSIVE_MONITOR 3'h6
// Addressing modes of block transfers.
`define LSMX_MODE_INCREMENT_AFTER 1'b0
`define LSMX_MODE_DECREMENT_BEFORE 1'b1
// Access sizes.
`define LSMX_SIZE_BYTE 2'h0
`define LSMX_SIZE_HALF 2'h1
`define LSMX_SIZE_WORD 2'h2
// Register numbers with special meaning.
`define LSMX_STACK_POINTER_REG 4'hd
`define LSMX_LINK_REG 4'he
`define LSMX_PROGRAM_COUNTER_REG 4'hf
// Address step between words of a block transfer.
`define LSMX_WORD_STEP 32'h0000_0004
// Status written by a store exclusive.
`define LSMX_STATUS_DONE 32'h0000_0000
`define LSMX_STATUS_FAIL 32'h0000_0001
// Reset values.
`define LSMX_RST_WORD 32'h0000_0000
`define LSMX_RST_LIST 16'h0000
`endif

// File: verilog/lsmx_unit.v
// Execution unit for load/store multiple, push/pop and exclusive transfers.
`timescale 1ns/1ns
`default_nettype none
`include "lsmx_regs.vh"
module lsmx_unit (
   // Clock and reset.
   input wire clk_in,
   input wire sys_rst_in,
   // Command from the instruction stream.
   input wire cmd_valid_in,
   input wire [2:0] cmd_op_in,
   input wire cmd_mode_in,
   input wire cmd_writeback_in,
   input wire [3:0] cmd_base_reg_in,
   input wire [31:0] cmd_base_value_in,
   input wire [15:0] cmd_list_in,
   input wire [1:0] cmd_size_in,
   input wire [3:0] cmd_transfer_reg_in,
   input wire [3:0] cmd_status_reg_in,
   input wire [7:0] cmd_offset_words_in,
   output reg cmd_ready_out,
   // Register file read port; data is expected in the same cycle as the index.
   output reg [3:0] rf_rd_idx_out,
   input wire [31:0] rf_rd_data_in,
   // Register file write port.
   output reg rf_we_out,
   output reg [3:0] rf_wr_idx_out,
   output reg [31:0] rf_wr_data_out,
   // Program counter loads.
   output reg branch_out,
   output reg [31:0] branch_addr_out,
   output reg pc_bit0_err_out,
   // Condition flag write enable, never raised by this unit.
   output reg flags_we_out,
   // Memory port.
   output reg mem_req_out,
   output reg mem_we_out,
   output reg [31:0] mem_addr_out,
   output reg [1:0] mem_size_out,
   output reg [31:0] mem_wdata_out,
   input wire mem_ack_in,
   input wire [31:0] mem_rdata_in,
   // Accesses made by other agents, used to drop the reservation.
   input wire snoop_valid_in,
   input wire [31:0] snoop_addr_in
);

   localparam S_IDLE = 3'd0;
   localparam S_NEXT = 3'd1;
   localparam S_READ = 3'd2;
   localparam S_MEM = 3'd3;

   ////////////////////////////////////////////////////////////////////////////
   // Helpers.

   function [3:0] lowest_reg;
      input [15:0] list;
      integer i;
      begin
         lowest_reg = 4'h0;
         for (i = 15; i >= 0; i = i - 1) begin
            if (list[i]) begin
               lowest_reg = i[3:0];
            end
         end
      end
   endfunction

   function [3:0] highest_reg;
      input [15:0] list;
      integer i;
      begin
         highest_reg = 4'h0;
         for (i = 0; i < 16; i = i + 1) begin
            if (list[i]) begin
               highest_reg = i[3:0];
            end
         end
      end
   endfunction

   function [31:0] size_mask;
      input [1:0] size;
      input [31:0] data;
      begin
         case (size)
            `LSMX_SIZE_BYTE: size_mask = {24'h00_0000, data[7:0]};
            `LSMX_SIZE_HALF: size_mask = {16'h0000, data[15:0]};
            default: size_mask = data;
         endcase
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // State.

   reg [2:0] state_ff;
   reg [15:0] list_ff;
   reg [31:0] addr_ff;
   reg [31:0] last_addr_ff;
   reg desc_ff;
   reg load_ff;
   reg writeback_ff;
   reg [3:0] base_reg_ff;
   reg [3:0] cur_reg_ff;
   reg [1:0] size_ff;
   reg excl_load_ff;
   reg excl_store_ff;
   reg [3:0] status_reg_ff;
   reg [31:0] status_ff;
   reg resv_valid_ff;
   reg [31:0] resv_addr_ff;
   reg [1:0] resv_size_ff;

   wire [2:0] op = cmd_op_in;
   wire is_push = (op == `LSMX_OP_PUSH);
   wire is_pop = (op == `LSMX_OP_POP);
   wire is_block = (op == `LSMX_OP_LOAD_MULTIPLE) || (op == `LSMX_OP_STORE_MULTIPLE) || is_push || is_pop;
   wire [31:0] excl_addr = cmd_base_value_in + {22'h00_0000, cmd_offset_words_in, 2'b00};
   wire resv_hit = resv_valid_ff && (resv_addr_ff == excl_addr) && (resv_size_ff == cmd_size_in);
   wire snoop_hit = snoop_valid_in && (snoop_addr_in[31:2] == resv_addr_ff[31:2]);
   wire [3:0] nxt_reg = desc_ff ? highest_reg(list_ff) : lowest_reg(list_ff);
   wire [31:0] nxt_addr = desc_ff ? addr_ff - `LSMX_WORD_STEP : addr_ff + `LSMX_WORD_STEP;
   wire [31:0] load_value = size_mask(size_ff, mem_rdata_in);

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer.

   always @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         state_ff <= S_IDLE;
         list_ff <= `LSMX_RST_LIST;
         addr_ff <= `LSMX_RST_WORD;
         last_addr_ff <= `LSMX_RST_WORD;
         desc_ff <= 1'b0;
         load_ff <= 1'b0;
         writeback_ff <= 1'b0;
         base_reg_ff <= 4'h0;
         cur_reg_ff <= 4'h0;
         size_ff <= `LSMX_SIZE_WORD;
         excl_load_ff <= 1'b0;
         excl_store_ff <= 1'b0;
         status_reg_ff <= 4'h0;
         status_ff <= `LSMX_STATUS_FAIL;
         resv_valid_ff <= 1'b0;
         resv_addr_ff <= `LSMX_RST_WORD;
         resv_size_ff <= `LSMX_SIZE_WORD;
         cmd_ready_out <= 1'b0;
         rf_rd_idx_out <= 4'h0;
         rf_we_out <= 1'b0;
         rf_wr_idx_out <= 4'h0;
         rf_wr_data_out <= `LSMX_RST_WORD;
         branch_out <= 1'b0;
         branch_addr_out <= `LSMX_RST_WORD;
         pc_bit0_err_out <= 1'b0;
         flags_we_out <= 1'b0;
         mem_req_out <= 1'b0;
         mem_we_out <= 1'b0;
         mem_addr_out <= `LSMX_RST_WORD;
         mem_size_out <= `LSMX_SIZE_WORD;
         mem_wdata_out <= `LSMX_RST_WORD;
      end else begin
         rf_we_out <= 1'b0;
         branch_out <= 1'b0;
         pc_bit0_err_out <= 1'b0;
         // Flags are left alone by every transfer.
         flags_we_out <= 1'b0;
         // Another agent touching the reserved word breaks exclusivity.
         if (snoop_hit) begin
            resv_valid_ff <= 1'b0;
         end
         case (state_ff)
            S_IDLE: begin
               cmd_ready_out <= 1'b1;
               if (cmd_valid_in && cmd_ready_out) begin
                  excl_load_ff <= 1'b0;
                  excl_store_ff <= 1'b0;
                  status_reg_ff <= cmd_status_reg_in;
                  if (op == `LSMX_OP_CLEAR_EXCLUSIVE_MONITOR) begin
                     resv_valid_ff <= 1'b0;
                  end else if (is_block) begin
                     cmd_ready_out <= 1'b0;
                     state_ff <= S_NEXT;
                     list_ff <= cmd_list_in;
                     addr_ff <= cmd_base_value_in;
                     last_addr_ff <= cmd_base_value_in;
                     size_ff <= `LSMX_SIZE_WORD;
                     load_ff <= (op == `LSMX_OP_LOAD_MULTIPLE) || is_pop;
                     // Stack forms fix base, mode and writeback.
                     if (is_push || is_pop) begin
                        desc_ff <= is_push;
                        writeback_ff <= 1'b1;
                        base_reg_ff <= `LSMX_STACK_POINTER_REG;
                     end else begin
                        desc_ff <= (cmd_mode_in == `LSMX_MODE_DECREMENT_BEFORE);
                        writeback_ff <= cmd_writeback_in;
                        base_reg_ff <= cmd_base_reg_in;
                     end
                  end else if (op == `LSMX_OP_LOAD_EXCLUSIVE || op == `LSMX_OP_STORE_EXCLUSIVE) begin
                     cmd_ready_out <= 1'b0;
                     state_ff <= S_NEXT;
                     addr_ff <= excl_addr;
                     size_ff <= cmd_size_in;
                     desc_ff <= 1'b0;
                     writeback_ff <= 1'b0;
                     load_ff <= (op == `LSMX_OP_LOAD_EXCLUSIVE);
                     excl_load_ff <= (op == `LSMX_OP_LOAD_EXCLUSIVE);
                     excl_store_ff <= (op == `LSMX_OP_STORE_EXCLUSIVE);
                     status_ff <= `LSMX_STATUS_FAIL;
                     if (op == `LSMX_OP_STORE_EXCLUSIVE) begin
                        // A store exclusive always consumes the reservation.
                        resv_valid_ff <= 1'b0;
                        // A missed reservation skips memory entirely.
                        list_ff <= (resv_hit && !snoop_hit) ? (16'h0001 << cmd_transfer_reg_in) : 16'h0000;
                     end else begin
                        list_ff <= 16'h0001 << cmd_transfer_reg_in;
                     end
                  end
               end
            end
            S_NEXT: begin
               if (list_ff == 16'h0000) begin
                  cmd_ready_out <= 1'b1;
                  state_ff <= S_IDLE;
                  if (excl_store_ff) begin
                     rf_we_out <= 1'b1;
                     rf_wr_idx_out <= status_reg_ff;
                     rf_wr_data_out <= status_ff;
                  end else if (writeback_ff) begin
                     rf_we_out <= 1'b1;
                     rf_wr_idx_out <= base_reg_ff;
                     rf_wr_data_out <= last_addr_ff;
                  end
               end else begin
                  cur_reg_ff <= nxt_reg;
                  mem_addr_out <= addr_ff;
                  mem_size_out <= size_ff;
                  if (load_ff) begin
                     mem_req_out <= 1'b1;
                     mem_we_out <= 1'b0;
                     state_ff <= S_MEM;
                  end else begin
                     rf_rd_idx_out <= nxt_reg;
                     state_ff <= S_READ;
                  end
               end
            end
            S_READ: begin
               mem_wdata_out <= size_mask(size_ff, rf_rd_data_in);
               mem_req_out <= 1'b1;
               mem_we_out <= 1'b1;
               state_ff <= S_MEM;
            end
            S_MEM: begin
               if (mem_ack_in) begin
                  mem_req_out <= 1'b0;
                  mem_we_out <= 1'b0;
                  list_ff <= list_ff & ~(16'h0001 << cur_reg_ff);
                  last_addr_ff <= addr_ff;
                  addr_ff <= nxt_addr;
                  state_ff <= S_NEXT;
                  if (excl_store_ff) begin
                     status_ff <= `LSMX_STATUS_DONE;
                  end
                  // The reservation is set after the snoop clear, so setting wins.
                  if (excl_load_ff) begin
                     resv_valid_ff <= 1'b1;
                     resv_addr_ff <= addr_ff;
                     resv_size_ff <= size_ff;
                  end
                  if (load_ff && cur_reg_ff == `LSMX_PROGRAM_COUNTER_REG) begin
                     branch_out <= 1'b1;
                     branch_addr_out <= {load_value[31:1], 1'b0};
                     pc_bit0_err_out <= ~load_value[0];
                  end else if (load_ff) begin
                     rf_we_out <= 1'b1;
                     rf_wr_idx_out <= cur_reg_ff;
                     rf_wr_data_out <= load_value;
                  end
               end
            end
            default: begin
               state_ff <= S_IDLE;
            end
         endcase
      end
   end

endmodule // lsmx_unit
`default_nettype wire

// File: bench/lsmx_unit_assertions.sv
// Concurrent checks on the block-transfer and exclusive unit.
`timescale 1ns/1ns
`default_nettype none
`include "lsmx_regs.vh"
module lsmx_unit_chk (
   // Clock, reset and command.
   input wire logic clk_in,
   input wire logic sys_rst_in,
   input wire logic cmd_valid_in,
   input wire logic [2:0] cmd_op_in,
   input wire logic cmd_ready_out,
   // Results and memory.
   input wire logic rf_we_out,
   input wire logic [31:0] rf_wr_data_out,
   input wire logic branch_out,
   input wire logic [31:0] branch_addr_out,
   input wire logic pc_bit0_err_out,
   input wire logic flags_we_out,
   input wire logic mem_req_out,
   input wire logic mem_we_out,
   input wire logic [31:0] mem_addr_out,
   input wire logic mem_ack_in
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (sys_rst_in);
   wire take = cmd_valid_in && cmd_ready_out;
   // No reservation survives reset, a clear or a store exclusive.
   logic gone_ff;
   always @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         gone_ff <= 1'b1;
      end else if (take && cmd_op_in >= `LSMX_OP_LOAD_EXCLUSIVE) begin
         gone_ff <= (cmd_op_in != `LSMX_OP_LOAD_EXCLUSIVE);
      end
   end
   a_flags_untouched: assert property (!flags_we_out) else $error("flag write seen");
   a_branch_aligned: assert property (branch_out |-> !branch_addr_out[0]) else $error("odd branch");
   a_bit0_err_pairs: assert property (pc_bit0_err_out |-> branch_out) else $error("lone bit0 error");
   a_req_held: assert property (mem_req_out && !mem_ack_in |=>
      mem_req_out && $stable(mem_addr_out) && $stable(mem_we_out)) else $error("request changed early");
   a_busy_then_done: assert property (take && cmd_op_in != `LSMX_OP_CLEAR_EXCLUSIVE_MONITOR |=>
      !cmd_ready_out ##[1:300] cmd_ready_out) else $error("busy state wrong");
   a_clear_no_stall: assert property (take && cmd_op_in == `LSMX_OP_CLEAR_EXCLUSIVE_MONITOR |=>
      cmd_ready_out) else $error("clear stalled");
   a_fail_no_write: assert property (take && cmd_op_in == `LSMX_OP_STORE_EXCLUSIVE && gone_ff |->
      !mem_req_out throughout (##[1:4] (rf_we_out && rf_wr_data_out == `LSMX_STATUS_FAIL)))
      else $error("failed store wrong");
   a_idle_no_req: assert property (cmd_ready_out |-> !mem_req_out) else $error("request while idle");
endmodule // lsmx_unit_chk
bind lsmx_unit lsmx_unit_chk u_chk (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .cmd_valid_in(cmd_valid_in),
   .cmd_op_in(cmd_op_in), .cmd_ready_out(cmd_ready_out), .rf_we_out(rf_we_out), .rf_wr_data_out(rf_wr_data_out),
   .branch_out(branch_out), .branch_addr_out(branch_addr_out), .pc_bit0_err_out(pc_bit0_err_out),
   .flags_we_out(flags_we_out), .mem_req_out(mem_req_out), .mem_we_out(mem_we_out),
   .mem_addr_out(mem_addr_out), .mem_ack_in(mem_ack_in));
`default_nettype wire

// File: bench/lsmx_mem_model.sv
// Memory partner for the unit's load/store port, with a settable wait.
`timescale 1ns/1ns
`default_nettype none
module lsmx_mem_model (
   // Clock, reset and wait setting.
   input wire logic clk_in,
   input wire logic sys_rst_in,
   input wire logic [3:0] lat_in,
   // Memory port.
   input wire logic req_in,
   input wire logic we_in,
   input wire logic [31:0] addr_in,
   input wire logic [1:0] size_in,
   input wire logic [31:0] wdata_in,
   output logic ack_out,
   output logic [31:0] rdata_out
);
   logic [31:0] mem [logic [31:0]];
   logic [3:0] cnt_ff;
   logic [31:0] w;
   always @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         ack_out <= 1'b0;
         cnt_ff <= 4'h0;
         rdata_out <= 32'h0000_0000;
      end else begin
         ack_out <= 1'b0;
         // Data toggles outside an answer, so a late sample cannot match by luck.
         rdata_out <= ~rdata_out;
         if (req_in && !ack_out && cnt_ff != lat_in) begin
            cnt_ff <= cnt_ff + 4'h1;
         end else if (req_in && !ack_out) begin
            cnt_ff <= 4'h0;
            ack_out <= 1'b1;
            w = mem.exists(addr_in) ? mem[addr_in] : ~addr_in;
            rdata_out <= w;
            if (we_in) begin
               mem[addr_in] = size_in == 2'h0 ? {w[31:8], wdata_in[7:0]} :
                  size_in == 2'h1 ? {w[31:16], wdata_in[15:0]} : wdata_in;
            end
         end
      end
   end
endmodule // lsmx_mem_model
`default_nettype wire

// File: bench/tb.sv
// Self-checking bench for the block-transfer and exclusive unit.
`timescale 1ns/1ns
`default_nettype none
`include "lsmx_regs.vh"
module tb;
   logic clk_in = 1'b0, sys_rst_in = 1'b1, valid = 1'b0, mode = 1'b0, wb = 1'b0, snp = 1'b0;
   logic [2:0] op = 3'h0;
   logic [3:0] breg = 4'h0, lat = 4'h0, rdi, wi;
   logic [31:0] bval = 32'h0000_0000, snp_a = 32'h0000_0000, rdd, wd, ba, ma, mwd, mrd, last_br;
   logic [15:0] list = 16'h0000;
   logic [1:0] sz = 2'h0, ms;
   logic ready, we, br, be, fl, mreq, mwe, ack, last_be;
   int n_fail = 0, n_compared = 0;
   logic [3:0] q_i [$];
   logic [31:0] q_d [$];
   lsmx_unit u_dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .cmd_valid_in(valid), .cmd_op_in(op),
      .cmd_mode_in(mode), .cmd_writeback_in(wb), .cmd_base_reg_in(breg), .cmd_base_value_in(bval),
      .cmd_list_in(list), .cmd_size_in(sz), .cmd_transfer_reg_in(4'h2), .cmd_status_reg_in(4'h3),
      .cmd_offset_words_in(8'h02), .cmd_ready_out(ready), .rf_rd_idx_out(rdi), .rf_rd_data_in(rdd),
      .rf_we_out(we), .rf_wr_idx_out(wi), .rf_wr_data_out(wd), .branch_out(br), .branch_addr_out(ba),
      .pc_bit0_err_out(be), .flags_we_out(fl), .mem_req_out(mreq), .mem_we_out(mwe), .mem_addr_out(ma),
      .mem_size_out(ms), .mem_wdata_out(mwd), .mem_ack_in(ack), .mem_rdata_in(mrd), .snoop_valid_in(snp),
      .snoop_addr_in(snp_a));
   lsmx_mem_model u_mem (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .lat_in(lat), .req_in(mreq), .we_in(mwe),
      .addr_in(ma), .size_in(ms), .wdata_in(mwd), .ack_out(ack), .rdata_out(mrd));
   initial begin
      forever #10 clk_in = ~clk_in;
   end
   function automatic logic [31:0] rv(input logic [3:0] i);
      return {28'hC0D_E5A5, i};
   endfunction
   // The register file answers in the same cycle as the index, so its data is not registered again.
   assign rdd = rv(rdi);
   always @(posedge clk_in) begin
      if (we === 1'b1) begin
         q_i.push_back(wi);
         q_d.push_back(wd);
      end
      if (br === 1'b1) begin
         {last_br, last_be} <= {ba, be};
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_wr(input int k, input logic [3:0] i, input logic [31:0] d);
      chk({28'h0, q_i[k]}, {28'h0, i});
      chk(q_d[k], d);
   endtask
   // Holds the command until taken, then waits for the unit to become idle again.
   task automatic issue(input logic [2:0] o, input logic m, input logic w, input logic [3:0] r,
                        input logic [31:0] b, input logic [15:0] l, input logic [1:0] s);
      q_i.delete();
      q_d.delete();
      @(posedge clk_in);
      while (ready !== 1'b1) @(posedge clk_in);
      {valid, op, mode, wb, breg, bval, list, sz} <= {1'b1, o, m, w, r, b, l, s};
      @(posedge clk_in);
      valid <= 1'b0;
      @(posedge clk_in);
      while (ready !== 1'b1) @(posedge clk_in);
      @(negedge clk_in);
   endtask
   task automatic t_ldm();
      u_mem.mem[32'h0000_1000] = 32'h1111_0001;
      u_mem.mem[32'h0000_1004] = 32'h2222_0002;
      u_mem.mem[32'h0000_1008] = 32'h0000_4A01;
      lat = 4'h2;
      issue(`LSMX_OP_LOAD_MULTIPLE, 1'b0, 1'b1, 4'h8, 32'h0000_1000, 16'h800A, 2'h2);
      chk(32'(q_i.size()), 32'h3);
      chk_wr(0, 4'h1, 32'h1111_0001);
      chk_wr(1, 4'h3, 32'h2222_0002);
      chk_wr(2, 4'h8, 32'h0000_1008);
      chk({last_br[31:1], last_be}, 32'h0000_4A00);
      u_mem.mem[32'h0000_100C] = 32'h0000_5B00;
      issue(`LSMX_OP_LOAD_MULTIPLE, 1'b0, 1'b0, 4'h8, 32'h0000_100C, 16'h8000, 2'h2);
      chk(last_br, 32'h0000_5B00);
      chk({31'h0, last_be}, 32'h0000_0001);
      chk(32'(q_i.size()), 32'h0);
      $display("block load increment-after done");
   endtask
   task automatic t_stm();
      lat = 4'h0;
      issue(`LSMX_OP_STORE_MULTIPLE, 1'b1, 1'b0, 4'h9, 32'h0000_2000, 16'h0024, 2'h2);
      chk(u_mem.mem[32'h0000_2000], rv(4'h5));
      chk(u_mem.mem[32'h0000_1FFC], rv(4'h2));
      chk(32'(q_i.size()), 32'h0);
      $display("block store decrement-before done");
   endtask
   task automatic t_stack();
      issue(`LSMX_OP_PUSH, 1'b1, 1'b1, 4'hd, 32'h0000_3000, 16'h4010, 2'h2);
      chk(u_mem.mem[32'h0000_3000], rv(4'he));
      chk(u_mem.mem[32'h0000_2FFC], rv(4'h4));
      chk_wr(0, 4'hd, 32'h0000_2FFC);
      lat = 4'h3;
      issue(`LSMX_OP_POP, 1'b0, 1'b1, 4'hd, 32'h0000_2FFC, 16'h4010, 2'h2);
      chk_wr(0, 4'h4, rv(4'h4));
      chk_wr(1, 4'he, rv(4'he));
      chk_wr(2, 4'hd, 32'h0000_3000);
      $display("push and pop done");
   endtask
   task automatic t_excl(input logic [1:0] s);
      logic [31:0] mk, exp;
      mk = s == 2'h0 ? 32'h0000_00FF : s == 2'h1 ? 32'h0000_FFFF : 32'hFFFF_FFFF;
      exp = (32'hA1B2_C3D4 & ~mk) | (rv(4'h2) & mk);
      u_mem.mem[32'h2000_0108] = 32'hA1B2_C3D4;
      issue(`LSMX_OP_LOAD_EXCLUSIVE, 1'b0, 1'b0, 4'h8, 32'h2000_0100, 16'h0000, s);
      chk_wr(0, 4'h2, 32'hA1B2_C3D4 & mk);
      issue(`LSMX_OP_STORE_EXCLUSIVE, 1'b0, 1'b0, 4'h8, 32'h2000_0100, 16'h0000, s);
      chk_wr(0, 4'h3, `LSMX_STATUS_DONE);
      chk(u_mem.mem[32'h2000_0108], exp);
      issue(`LSMX_OP_LOAD_EXCLUSIVE, 1'b0, 1'b0, 4'h8, 32'h2000_0100, 16'h0000, s);
      issue(`LSMX_OP_CLEAR_EXCLUSIVE_MONITOR, 1'b0, 1'b0, 4'h0, 32'h0000_0000, 16'h0000, 2'h0);
      issue(`LSMX_OP_STORE_EXCLUSIVE, 1'b0, 1'b0, 4'h8, 32'h2000_0100, 16'h0000, s);
      chk_wr(0, 4'h3, `LSMX_STATUS_FAIL);
      issue(`LSMX_OP_LOAD_EXCLUSIVE, 1'b0, 1'b0, 4'h8, 32'h2000_0100, 16'h0000, s);
      @(posedge clk_in);
      {snp, snp_a} <= {1'b1, 32'h2000_0108};
      @(posedge clk_in);
      snp <= 1'b0;
      issue(`LSMX_OP_STORE_EXCLUSIVE, 1'b0, 1'b0, 4'h8, 32'h2000_0100, 16'h0000, s);
      chk_wr(0, 4'h3, `LSMX_STATUS_FAIL);
      chk(u_mem.mem[32'h2000_0108], exp);
      $display("exclusive size %0d done", s);
   endtask
   task automatic wrap_up();
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   initial begin
      repeat (12) @(posedge clk_in);
      sys_rst_in <= 1'b0;
      @(posedge clk_in);
      t_ldm();
      t_stm();
      t_stack();
      for (int s = 0; s < 3; s++) begin
         t_excl(2'(s));
      end
      wrap_up();
   end
   // All tests need about 300 cycles; this limit is far beyond that.
   initial begin
      #400000;
      n_fail++;
      wrap_up();
   end
endmodule // tb
`default_nettype wire
